/* File: frtc_pkg.sv */
// package of constants and types for the free-running timer with capture
// Overview of operation
// - sixteen-bit up counter, byte pair plus shadow pair
// - writing either low count byte loads FFFC
// - reset and only reload value is FFFC
// - prescaler divides cpu clock by 2, 4, 8
// - select code 11 picks external clock pin
// - edge select bit picks external active edge
// - external counting synchronised to cpu clock
// - high byte read freezes low byte buffer
// - lone low byte read returns live count
// - wrap FFFF to 0000 sets overflow flag
// - overflow interrupt needs enable and clear mask
// - status read then count low access clears overflow
// - shadow low byte access never clears overflow
// - runs in wait, freezes in halt
// - two capture registers latch count on edge
// - per channel edge select bit picks polarity
// - capture sets flag, interrupt when enabled, unmasked
// - status read then capture low access clears flag
// - capture high read blocks channel until low read
// - only capture pin two always reaches the timer
// - pulse or pwm modes leave only channel two
package frtc_pkg;
  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [7:0] FRTC_CTRL1_ADDR = 8'h00;
  localparam logic [7:0] FRTC_CTRL2_ADDR = 8'h04;
  localparam logic [7:0] FRTC_STATUS_ADDR = 8'h08;
  localparam logic [7:0] FRTC_CAP1_HI_ADDR = 8'h0C;
  localparam logic [7:0] FRTC_CAP1_LO_ADDR = 8'h10;
  localparam logic [7:0] FRTC_CAP2_HI_ADDR = 8'h14;
  localparam logic [7:0] FRTC_CAP2_LO_ADDR = 8'h18;
  localparam logic [7:0] FRTC_CNT_HI_ADDR = 8'h1C;
  localparam logic [7:0] FRTC_CNT_LO_ADDR = 8'h20;
  localparam logic [7:0] FRTC_SHD_HI_ADDR = 8'h24;
  localparam logic [7:0] FRTC_SHD_LO_ADDR = 8'h28;
  // ****************************************
  // field positions
  // ****************************************
  localparam int FRTC_C1_EDGE1_BIT = 1;
  localparam int FRTC_C1_OVF_IE_BIT = 5;
  localparam int FRTC_C1_CAP_IE_BIT = 7;
  localparam int FRTC_C2_EXT_EDGE_BIT = 0;
  localparam int FRTC_C2_EDGE2_BIT = 1;
  localparam int FRTC_C2_CLKSEL_LSB = 2;
  localparam int FRTC_C2_PWM_BIT = 4;
  localparam int FRTC_C2_ONE_PULSE_BIT = 5;
  localparam int FRTC_ST_OVF_BIT = 5;
  localparam int FRTC_ST_CAP2_BIT = 4;
  localparam int FRTC_ST_CAP1_BIT = 7;
  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [15:0] FRTC_COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] FRTC_COUNT_TOP = 16'hFFFF;
  localparam logic [7:0] FRTC_CTRL_RESET = 8'h00;
  localparam logic [1:0] FRTC_SEL_EXT = 2'h3;
  localparam logic [2:0] FRTC_DIV2_MASK = 3'h1;
  localparam logic [2:0] FRTC_DIV4_MASK = 3'h3;
  localparam logic [2:0] FRTC_DIV8_MASK = 3'h7;
  localparam logic [31:0] FRTC_PSLVERR_NONE = 32'h0000_0000;

  typedef struct packed {
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
  } frtc_ctrl_t;

  typedef enum logic [1:0] {
    FRTC_RD_LIVE = 2'b01,
    FRTC_RD_HELD = 2'b10
  } frtc_rdseq_t;
endpackage

/* File: frtc_timer.sv */
// free-running 16-bit timer with two input capture channels, apb slave
`timescale 1ns/100ps
module frtc_timer
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_timer_clock_pin,
  input wire logic [1:0] capture_input_pin,
  input wire logic condition_code_register,
  input wire logic halt_mode,
  output logic timer_irq,
  output logic [15:0] counter_word
);
  import frtc_pkg::*;

  // ****************************************
  // bus decode
  // ****************************************
  logic acc;
  logic wr;
  logic rd;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  // edge at which read data is registered
  logic rd_sample;
  assign rd_sample = psel && penable && !pready && !pwrite;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  frtc_ctrl_t ctrl_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic overflow_flag_r;
  logic [1:0] capture_flag_r;
  logic [15:0] cap_r [2];
  logic [1:0] cap_block_r;
  logic ovf_armed_r;
  logic [1:0] cap_armed_r;
  logic [7:0] lo_buf_r;
  frtc_rdseq_t rdseq_r;
  logic [2:0] pre_r;
  logic ext_s1_r;
  logic ext_s2_r;
  logic ext_d_r;
  logic [1:0] cap_s1_r;
  logic [1:0] cap_s2_r;
  logic [1:0] cap_d_r;
  logic tick;
  logic ext_tick;
  logic [1:0] cap_edge;
  logic [1:0] clk_sel;
  logic pulse_modes;

  assign clk_sel = ctrl_r.ctrl2[FRTC_C2_CLKSEL_LSB +: 2];
  assign pulse_modes = ctrl_r.ctrl2[FRTC_C2_ONE_PULSE_BIT] | ctrl_r.ctrl2[FRTC_C2_PWM_BIT];

  // ****************************************
  // input synchronisers
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_d_r <= 1'b0;
      cap_s1_r <= 2'h0;
      cap_s2_r <= 2'h0;
      cap_d_r <= 2'h0;
    end
    else
    begin
      ext_s1_r <= external_timer_clock_pin;
      ext_s2_r <= ext_s1_r;
      ext_d_r <= ext_s2_r;
      cap_s1_r <= capture_input_pin;
      cap_s2_r <= cap_s1_r;
      cap_d_r <= cap_s2_r;
    end
  end

  // rising when edge bit set, falling otherwise
  assign ext_tick = ctrl_r.ctrl2[FRTC_C2_EXT_EDGE_BIT] ? (ext_s2_r && !ext_d_r)
                                                       : (!ext_s2_r && ext_d_r);

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_edge
      logic pol;
      assign pol = (g == 0) ? ctrl_r.ctrl1[FRTC_C1_EDGE1_BIT] : ctrl_r.ctrl2[FRTC_C2_EDGE2_BIT];
      assign cap_edge[g] = pol ? (cap_s2_r[g] && !cap_d_r[g]) : (!cap_s2_r[g] && cap_d_r[g]);
    end
  endgenerate

  // ****************************************
  // prescaler
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      pre_r <= 3'h0;
    else if (!halt_mode)
      pre_r <= pre_r + 3'h1;
  end

  always_comb
  begin
    if (halt_mode)
      tick = 1'b0;
    else if (clk_sel == FRTC_SEL_EXT)
      tick = ext_tick;
    else if (clk_sel == 2'h0)
      tick = (pre_r & FRTC_DIV2_MASK) == FRTC_DIV2_MASK;
    else if (clk_sel == 2'h1)
      tick = (pre_r & FRTC_DIV4_MASK) == FRTC_DIV4_MASK;
    else
      tick = (pre_r & FRTC_DIV8_MASK) == FRTC_DIV8_MASK;
  end

  // ****************************************
  // counter
  // ****************************************
  always_comb
  begin
    count_nxt = count_r;
    if (wr && (hit(paddr, FRTC_CNT_LO_ADDR) || hit(paddr, FRTC_SHD_LO_ADDR)))
      count_nxt = FRTC_COUNT_RESET;
    else if (tick)
      count_nxt = count_r + 16'h1;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      count_r <= FRTC_COUNT_RESET;
    else
      count_r <= count_nxt;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      counter_word <= FRTC_COUNT_RESET;
    else
      counter_word <= count_nxt;
  end

  // ****************************************
  // 16-bit read sequence
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdseq_r <= FRTC_RD_LIVE;
    end
    else if (rd)
    begin
      case (rdseq_r)
        FRTC_RD_LIVE:
        begin
          if (hit(paddr, FRTC_CNT_HI_ADDR) || hit(paddr, FRTC_SHD_HI_ADDR))
            rdseq_r <= FRTC_RD_HELD;
        end
        FRTC_RD_HELD:
        begin
          if (hit(paddr, FRTC_CNT_LO_ADDR) || hit(paddr, FRTC_SHD_LO_ADDR))
            rdseq_r <= FRTC_RD_LIVE;
        end
        default:
          rdseq_r <= FRTC_RD_LIVE;
      endcase
    end
  end

  // low byte taken with the high byte data
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      lo_buf_r <= 8'h00;
    else if (rd_sample && rdseq_r == FRTC_RD_LIVE &&
             (hit(paddr, FRTC_CNT_HI_ADDR) || hit(paddr, FRTC_SHD_HI_ADDR)))
      lo_buf_r <= count_r[7:0];
  end

  // ****************************************
  // control registers
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_r <= '{ctrl1: FRTC_CTRL_RESET, ctrl2: FRTC_CTRL_RESET};
    else if (wr && hit(paddr, FRTC_CTRL1_ADDR))
      ctrl_r.ctrl1 <= pwdata[7:0];
    else if (wr && hit(paddr, FRTC_CTRL2_ADDR))
      ctrl_r.ctrl2 <= pwdata[7:0];
  end

  // ****************************************
  // overflow flag
  // ****************************************
  logic st_rd;
  assign st_rd = rd && hit(paddr, FRTC_STATUS_ADDR);

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      overflow_flag_r <= 1'b0;
      ovf_armed_r <= 1'b0;
    end
    else
    begin
      if (st_rd && overflow_flag_r)
        ovf_armed_r <= 1'b1;
      else if (acc && hit(paddr, FRTC_CNT_LO_ADDR))
        ovf_armed_r <= 1'b0;
      if (tick && count_r == FRTC_COUNT_TOP && count_nxt == 16'h0000)
        overflow_flag_r <= 1'b1;
      else if (acc && hit(paddr, FRTC_CNT_LO_ADDR) && ovf_armed_r)
        overflow_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // capture channels
  // ****************************************
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_cap
      logic [7:0] hi_a;
      logic [7:0] lo_a;
      logic en;
      assign hi_a = (g == 0) ? FRTC_CAP1_HI_ADDR : FRTC_CAP2_HI_ADDR;
      assign lo_a = (g == 0) ? FRTC_CAP1_LO_ADDR : FRTC_CAP2_LO_ADDR;
      assign en = (g == 1) || !pulse_modes;
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
        begin
          cap_r[g] <= 16'h0000;
          capture_flag_r[g] <= 1'b0;
          cap_block_r[g] <= 1'b0;
          cap_armed_r[g] <= 1'b0;
        end
        else
        begin
          if (rd_sample && hit(paddr, hi_a))
            cap_block_r[g] <= 1'b1;
          else if (rd && hit(paddr, lo_a))
            cap_block_r[g] <= 1'b0;
          if (st_rd && capture_flag_r[g])
            cap_armed_r[g] <= 1'b1;
          else if (acc && hit(paddr, lo_a))
            cap_armed_r[g] <= 1'b0;
          if (cap_edge[g] && en && !cap_block_r[g] && !(rd_sample && hit(paddr, hi_a)))
          begin
            cap_r[g] <= count_r;
            capture_flag_r[g] <= 1'b1;
          end
          else if (acc && hit(paddr, lo_a) && cap_armed_r[g])
            capture_flag_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // interrupt
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      timer_irq <= 1'b0;
    else
      timer_irq <= !condition_code_register &&
        ((overflow_flag_r && ctrl_r.ctrl1[FRTC_C1_OVF_IE_BIT]) ||
         ((|capture_flag_r) && ctrl_r.ctrl1[FRTC_C1_CAP_IE_BIT]));
  end

  // ****************************************
  // apb read data
  // ****************************************
  logic [7:0] rbyte;
  always_comb
  begin
    rbyte = 8'h00;
    if (hit(paddr, FRTC_CTRL1_ADDR))
      rbyte = ctrl_r.ctrl1;
    else if (hit(paddr, FRTC_CTRL2_ADDR))
      rbyte = ctrl_r.ctrl2;
    else if (hit(paddr, FRTC_STATUS_ADDR))
    begin
      rbyte[FRTC_ST_CAP1_BIT] = capture_flag_r[0];
      rbyte[FRTC_ST_CAP2_BIT] = capture_flag_r[1];
      rbyte[FRTC_ST_OVF_BIT] = overflow_flag_r;
    end
    else if (hit(paddr, FRTC_CAP1_HI_ADDR))
      rbyte = cap_r[0][15:8];
    else if (hit(paddr, FRTC_CAP1_LO_ADDR))
      rbyte = cap_r[0][7:0];
    else if (hit(paddr, FRTC_CAP2_HI_ADDR))
      rbyte = cap_r[1][15:8];
    else if (hit(paddr, FRTC_CAP2_LO_ADDR))
      rbyte = cap_r[1][7:0];
    else if (hit(paddr, FRTC_CNT_HI_ADDR) || hit(paddr, FRTC_SHD_HI_ADDR))
      rbyte = count_r[15:8];
    else if (hit(paddr, FRTC_CNT_LO_ADDR) || hit(paddr, FRTC_SHD_LO_ADDR))
      rbyte = (rdseq_r == FRTC_RD_HELD) ? lo_buf_r : count_r[7:0];
  end

  // one wait state: setup, access with pready low, then pready high
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      prdata <= {24'h000000, rbyte};
      pslverr <= (FRTC_PSLVERR_NONE != 32'h0000_0000);
    end
  end
endmodule

/* File: frtc_properties.sv */
// port-level checker for the free-running timer with capture
`timescale 1ns/100ps
module frtc_properties
  import frtc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_timer_clock_pin,
  input wire logic [1:0] capture_input_pin,
  input wire logic condition_code_register,
  input wire logic halt_mode,
  input wire logic timer_irq,
  input wire logic [15:0] counter_word
);
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic wr_take;
  assign wr_take = psel && penable && pready && pwrite;
  // shadow of the control registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl1_r <= FRTC_CTRL_RESET;
      ctrl2_r <= FRTC_CTRL_RESET;
    end
    else if (wr_take && paddr == FRTC_CTRL1_ADDR)
      ctrl1_r <= pwdata[7:0];
    else if (wr_take && paddr == FRTC_CTRL2_ADDR)
      ctrl2_r <= pwdata[7:0];
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_count: assert property (disable iff (1'b0) rst |=> counter_word == FRTC_COUNT_RESET)
    else $error("count not at reload value in reset");
  a_count_step: assert property (!$stable(counter_word) |->
    counter_word == $past(counter_word) + 16'h1 || counter_word == FRTC_COUNT_RESET)
    else $error("count moved by other than one");
  a_div_rate: assert property ((ctrl2_r[3:2] == 2'h0 && !halt_mode && !psel)[*4] |->
    counter_word == $past(counter_word, 2) + 16'h1)
    else $error("divide by two rate wrong");
  a_halt_freeze: assert property ((halt_mode && !psel)[*3] |-> $stable(counter_word))
    else $error("count moved in halt");
  a_write_reload: assert property (wr_take && (paddr == FRTC_CNT_LO_ADDR || paddr == FRTC_SHD_LO_ADDR)
    |-> ##[1:2] counter_word == FRTC_COUNT_RESET)
    else $error("low byte write did not reload");
  a_ovf_irq: assert property ($past(counter_word) == FRTC_COUNT_TOP && counter_word == 16'h0000 &&
    ctrl1_r[5] && !condition_code_register |-> ##[1:2] timer_irq)
    else $error("overflow gave no interrupt");
  a_mask_irq: assert property ($past(condition_code_register) && condition_code_register |-> !timer_irq)
    else $error("interrupt while masked");
  a_irq_enables: assert property ((!(ctrl1_r[5] || ctrl1_r[7]))[*2] |-> !timer_irq)
    else $error("interrupt with all enables off");
endmodule

bind frtc_timer frtc_properties props_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .external_timer_clock_pin, .capture_input_pin, .condition_code_register,
  .halt_mode, .timer_irq, .counter_word);

/* File: frtc_pulse_src.sv */
// pulse sources for the external clock and capture pins
`timescale 1ns/100ps
module frtc_pulse_src
(
  input wire logic mclk,
  output logic ext_clk,
  output logic [1:0] cap
);
  initial
  begin
    ext_clk = 1'b0;
    cap = 2'b00;
  end
  // pin 2 is the clock, 0 and 1 the capture pins
  task automatic drive(input int pin, input logic v);
    @(posedge mclk);
    if (pin == 2)
      ext_clk <= v;
    else
      cap[pin] <= v;
    repeat (5) @(posedge mclk);
  endtask
endmodule

/* File: free_running_timer_with_capture_tb.sv */
// testbench for the free-running timer with capture
`timescale 1ns/100ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin n_mismatch++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module free_running_timer_with_capture_tb;
  import frtc_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic condition_code_register = 1'b1;
  logic halt_mode = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, timer_irq, external_timer_clock_pin;
  logic [1:0] capture_input_pin;
  logic [15:0] counter_word;
  int n_mismatch = 0;
  int comparisons = 0;
  initial forever #50 mclk = ~mclk;
  frtc_timer dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_timer_clock_pin, .capture_input_pin, .condition_code_register, .halt_mode, .timer_irq,
    .counter_word);
  frtc_pulse_src src_u (.mclk(mclk), .ext_clk(external_timer_clock_pin), .cap(capture_input_pin));
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    `CHK("pslverr", 1'b0, pslverr)
    rd = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [7:0] d;
    bus(1'b1, a, v, d);
  endtask
  task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    bus(1'b0, a, 8'h00, d);
    `CHK(n, e, d)
  endtask
  task automatic pulses(input int n);
    repeat (n)
    begin
      src_u.drive(2, 1'b1);
      src_u.drive(2, 1'b0);
    end
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #600000;
    n_mismatch++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    `CHK("count", 16'hFFFC, counter_word)
    repeat (12) @(posedge mclk);
    halt_mode <= 1'b1;
    repeat (6) @(posedge mclk);
    `CHK("count", 16'h0002, counter_word)
    halt_mode <= 1'b0;
    wr(8'h3C, 8'h55);
    rc("unmapped", 8'h3C, 8'h00);
    wr(FRTC_CTRL2_ADDR, 8'h0D);
    wr(FRTC_CNT_LO_ADDR, 8'h00);
    rc("lo", FRTC_CNT_LO_ADDR, 8'hFC);
    pulses(1);
    wr(FRTC_SHD_LO_ADDR, 8'h00);
    rc("shadow lo", FRTC_SHD_LO_ADDR, 8'hFC);
    pulses(3);
    rc("hi", FRTC_CNT_HI_ADDR, 8'hFF);
    pulses(2);
    rc("hi", FRTC_CNT_HI_ADDR, 8'h00);
    rc("lo", FRTC_CNT_LO_ADDR, 8'hFF);
    rc("lo", FRTC_CNT_LO_ADDR, 8'h01);
    rc("status", FRTC_STATUS_ADDR, 8'h20);
    rc("shadow lo", FRTC_SHD_LO_ADDR, 8'h01);
    rc("status", FRTC_STATUS_ADDR, 8'h20);
    rc("lo", FRTC_CNT_LO_ADDR, 8'h01);
    rc("status", FRTC_STATUS_ADDR, 8'h00);
    wr(FRTC_CTRL1_ADDR, 8'h20);
    wr(FRTC_CNT_LO_ADDR, 8'h00);
    pulses(4);
    `CHK("irq", 1'b0, timer_irq)
    condition_code_register <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("irq", 1'b1, timer_irq)
    rc("status", FRTC_STATUS_ADDR, 8'h20);
    rc("lo", FRTC_CNT_LO_ADDR, 8'h00);
    repeat (2) @(posedge mclk);
    `CHK("irq", 1'b0, timer_irq)
    wr(FRTC_CNT_LO_ADDR, 8'h00);
    pulses(4);
    `CHK("irq", 1'b1, timer_irq)
    rc("status", FRTC_STATUS_ADDR, 8'h20);
    rc("lo", FRTC_CNT_LO_ADDR, 8'h00);
    wr(FRTC_CTRL1_ADDR, 8'h82);
    wr(FRTC_CTRL2_ADDR, 8'h0C);
    wr(FRTC_CNT_LO_ADDR, 8'h00);
    src_u.drive(2, 1'b1);
    rc("lo", FRTC_CNT_LO_ADDR, 8'hFC);
    src_u.drive(2, 1'b0);
    rc("lo", FRTC_CNT_LO_ADDR, 8'hFD);
    src_u.drive(0, 1'b1);
    `CHK("irq", 1'b1, timer_irq)
    rc("status", FRTC_STATUS_ADDR, 8'h80);
    rc("cap1 hi", FRTC_CAP1_HI_ADDR, 8'hFF);
    rc("cap1 lo", FRTC_CAP1_LO_ADDR, 8'hFD);
    src_u.drive(0, 1'b0);
    rc("status", FRTC_STATUS_ADDR, 8'h00);
    rc("cap1 hi", FRTC_CAP1_HI_ADDR, 8'hFF);
    pulses(1);
    src_u.drive(0, 1'b1);
    rc("status", FRTC_STATUS_ADDR, 8'h00);
    rc("cap1 lo", FRTC_CAP1_LO_ADDR, 8'hFD);
    src_u.drive(0, 1'b0);
    src_u.drive(0, 1'b1);
    rc("cap1 lo", FRTC_CAP1_LO_ADDR, 8'hFE);
    rc("status", FRTC_STATUS_ADDR, 8'h80);
    src_u.drive(1, 1'b1);
    src_u.drive(1, 1'b0);
    rc("status", FRTC_STATUS_ADDR, 8'h90);
    rc("cap2 lo", FRTC_CAP2_LO_ADDR, 8'hFE);
    rc("cap1 lo", FRTC_CAP1_LO_ADDR, 8'hFE);
    rc("status", FRTC_STATUS_ADDR, 8'h00);
    wr(FRTC_CTRL2_ADDR, 8'h2C);
    src_u.drive(0, 1'b0);
    src_u.drive(0, 1'b1);
    src_u.drive(1, 1'b1);
    src_u.drive(1, 1'b0);
    rc("status", FRTC_STATUS_ADDR, 8'h10);
    end_of_test();
  end
endmodule
